// *** include/msx_pkg.sv ***
// Package with operation codes, field widths and reset values for the executor.
`default_nettype none
package msx_pkg;
    // Operations presented by the instruction decoder.
    typedef enum logic [3:0] {
        MSX_OP_NONE,
        MSX_OP_LOGICAL_RIGHT_SHIFT,
        MSX_OP_INDIRECT_LOAD,
        MSX_OP_INDIRECT_STORE,
        MSX_OP_BANK_LITERAL_LOAD,
        MSX_OP_PAGE_LITERAL_LOAD,
        MSX_OP_LITERAL_TO_ACCUM,
        MSX_OP_ACCUM_TO_FILE
    } msx_op_t;

    // Pointer mode field encodings.
    localparam logic [1:0] MSX_MODE_PRE_INC  = 2'h0;
    localparam logic [1:0] MSX_MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0] MSX_MODE_POST_INC = 2'h2;
    localparam logic [1:0] MSX_MODE_POST_DEC = 2'h3;

    // Widths of the architectural registers and fields; number of pointers.
    localparam int MSX_DATA_W   = 8;
    localparam int MSX_PTR_W    = 16;
    localparam int MSX_FADDR_W  = 7;
    localparam int MSX_BANK_W   = 5;
    localparam int MSX_PAGE_W   = 7;
    localparam int MSX_OFS_W    = 6;
    localparam int MSX_NUM_PTR  = 2;

    // Reset values and the pointer step.
    localparam logic [7:0]  MSX_ACCUM_RST = 8'h00;
    localparam logic [15:0] MSX_PTR_RST   = 16'h0000;
    localparam logic [4:0]  MSX_BANK_RST  = 5'h00;
    localparam logic [6:0]  MSX_PAGE_RST  = 7'h00;
    localparam logic [15:0] MSX_PTR_STEP  = 16'h0001;
endpackage : msx_pkg
`default_nettype wire

// *** hdl/msx_ptr_unit.sv ***
// Pointer address generation unit for one file pointer.
`timescale 1ns/1ps
`default_nettype none
module msx_ptr_unit (
    // Pointer value and instruction fields.
    input  wire logic [15:0] i_ptr,
    input  wire logic [1:0]  i_mode,
    input  wire logic        i_relative,
    input  wire logic [5:0]  i_offset,
    // Results.
    output logic      [15:0] o_eff_addr,
    output logic      [15:0] o_next_ptr
);
    // Signed offset extended to pointer width; 16-bit arithmetic wraps.
    wire logic [15:0] offset_ext = {{10{i_offset[5]}}, i_offset};
    wire logic [15:0] ptr_inc = i_ptr + msx_pkg::MSX_PTR_STEP;
    wire logic [15:0] ptr_dec = i_ptr - msx_pkg::MSX_PTR_STEP;
    wire logic        is_dec  = i_mode[0];
    wire logic        is_pre  = ~i_mode[1];
    wire logic [15:0] stepped = is_dec ? ptr_dec : ptr_inc;

    // Effective address: pointer plus offset for relative form, else adjusted for pre modes, raw for post modes.
    assign o_eff_addr = i_relative ? i_ptr + offset_ext
                      : (is_pre ? stepped : i_ptr);
    // Pointer after the move: stepped, or unchanged for relative form.
    assign o_next_ptr = i_relative ? i_ptr : stepped;
endmodule : msx_ptr_unit
`default_nettype wire

// *** hdl/msx_exec.sv ***
// Executor for shift, indirect move and literal move operations.
`timescale 1ns/1ps
`default_nettype none
module msx_exec #(
    parameter int NUM_PTR = msx_pkg::MSX_NUM_PTR
) (
    // Clock and reset.
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // Decoded instruction, valid for one cycle.
    input  wire logic        i_valid,
    input  wire logic [3:0]  i_op,
    input  wire logic [6:0]  i_file_addr,
    input  wire logic        i_dest_sel,
    input  wire logic [7:0]  i_literal,
    input  wire logic        i_ptr_sel,
    input  wire logic [1:0]  i_pointer_mode_field,
    input  wire logic        i_relative,
    input  wire logic [5:0]  i_offset,
    // File operand as read by the core at i_file_addr.
    input  wire logic [7:0]  i_file_rdata,
    // Data memory read data for the indirect address.
    input  wire logic [7:0]  i_mem_rdata,
    // File register write port.
    output logic             o_file_we,
    output logic      [6:0]  o_file_waddr,
    output logic      [7:0]  o_file_wdata,
    // Data memory port for indirect access.
    output logic      [15:0] o_mem_addr,
    output logic             o_mem_we,
    output logic      [7:0]  o_mem_wdata,
    // Architectural state.
    output logic      [7:0]  o_accum,
    output logic             o_carry,
    output logic             o_zero,
    output logic      [4:0]  o_bank_select_reg,
    output logic      [6:0]  o_pc_high_latch,
    output logic      [15:0] o_file_pointer0,
    output logic      [15:0] o_file_pointer1
);
    logic [7:0]  accum_q;
    logic        carry_q;
    logic        zero_q;
    logic [4:0]  bank_q;
    logic [6:0]  page_q;
    logic [15:0] ptr_q [NUM_PTR];
    logic [15:0] ptr_d [NUM_PTR];
    logic [15:0] eff_addr [NUM_PTR];
    logic [15:0] next_ptr [NUM_PTR];

    // Operation decode.
    wire logic op_shr   = i_valid &&
        (i_op == 4'(msx_pkg::MSX_OP_LOGICAL_RIGHT_SHIFT));
    wire logic op_ild   = i_valid &&
        (i_op == 4'(msx_pkg::MSX_OP_INDIRECT_LOAD));
    wire logic op_ist   = i_valid &&
        (i_op == 4'(msx_pkg::MSX_OP_INDIRECT_STORE));
    wire logic op_bank  = i_valid &&
        (i_op == 4'(msx_pkg::MSX_OP_BANK_LITERAL_LOAD));
    wire logic op_page  = i_valid &&
        (i_op == 4'(msx_pkg::MSX_OP_PAGE_LITERAL_LOAD));
    wire logic op_lit   = i_valid &&
        (i_op == 4'(msx_pkg::MSX_OP_LITERAL_TO_ACCUM));
    wire logic op_a2f   = i_valid &&
        (i_op == 4'(msx_pkg::MSX_OP_ACCUM_TO_FILE));
    wire logic op_ind   = op_ild || op_ist;

    // Shift datapath: zero into MSb, bit 0 out to carry.
    wire logic [7:0] shr_result = {1'b0, i_file_rdata[7:1]};
    wire logic       shr_carry  = i_file_rdata[0];
    wire logic       shr_zero   = (shr_result == 8'h00);
    wire logic       ild_zero   = (i_mem_rdata == 8'h00);

    // One address unit per pointer; the selected one drives memory.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
            msx_ptr_unit u_ptr (
                .i_ptr      (ptr_q[gi]),
                .i_mode     (i_pointer_mode_field),
                .i_relative (i_relative),
                .i_offset   (i_offset),
                .o_eff_addr (eff_addr[gi]),
                .o_next_ptr (next_ptr[gi])
            );
            // Only the selected pointer moves, and only on indirect ops.
            assign ptr_d[gi] = (op_ind && (i_ptr_sel == 1'(gi)))
                             ? next_ptr[gi] : ptr_q[gi];

            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    ptr_q[gi] <= msx_pkg::MSX_PTR_RST;
                end else begin
                    ptr_q[gi] <= ptr_d[gi];
                end
            end
        end
    endgenerate

    // The window has no storage; the pointer address goes to memory.
    wire logic [15:0] sel_eff = i_ptr_sel ? eff_addr[1] : eff_addr[0];
    assign o_mem_addr  = sel_eff;
    assign o_mem_we    = op_ist;
    assign o_mem_wdata = accum_q;

    // File write port: shift write-back or accumulator copy.
    wire logic shr_to_file = op_shr && i_dest_sel;
    assign o_file_we    = shr_to_file || op_a2f;
    assign o_file_waddr = i_file_addr;
    assign o_file_wdata = op_a2f ? accum_q : shr_result;

    // Next accumulator; literal load completes in this single cycle.
    wire logic [7:0] accum_d =
        (op_shr && !i_dest_sel) ? shr_result :
        op_ild ? i_mem_rdata :
        op_lit ? i_literal : accum_q;

    // Flags change only from the shift and the indirect load data.
    wire logic carry_d = op_shr ? shr_carry : carry_q;
    wire logic zero_d  = op_shr ? shr_zero
                       : op_ild ? ild_zero : zero_q;

    // Accumulator and flags.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            accum_q <= msx_pkg::MSX_ACCUM_RST;
            carry_q <= 1'b0;
            zero_q  <= 1'b0;
        end else begin
            accum_q <= accum_d;
            carry_q <= carry_d;
            zero_q  <= zero_d;
        end
    end

    // Literal targets; these never touch the flags.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bank_q <= msx_pkg::MSX_BANK_RST;
            page_q <= msx_pkg::MSX_PAGE_RST;
        end else begin
            if (op_bank) begin
                bank_q <= i_literal[4:0];
            end
            if (op_page) begin
                page_q <= i_literal[6:0];
            end
        end
    end

    // State outputs straight from flip-flops.
    assign o_accum           = accum_q;
    assign o_carry           = carry_q;
    assign o_zero            = zero_q;
    assign o_bank_select_reg = bank_q;
    assign o_pc_high_latch   = page_q;
    assign o_file_pointer0   = ptr_q[0];
    assign o_file_pointer1   = ptr_q[1];
endmodule : msx_exec
`default_nettype wire

// *** tb/msx_exec_monitor.sv ***
// Checker that watches the executor's ports.
`timescale 1ns/1ps
`default_nettype none
module msx_exec_monitor (
    // Watched ports.
    input wire logic        i_ref_clk, i_rstn, i_valid, i_ptr_sel,
    input wire logic        i_relative, i_dest_sel, o_file_we, o_mem_we,
    input wire logic        o_carry, o_zero,
    input wire logic [3:0]  i_op,
    input wire logic [1:0]  i_pointer_mode_field,
    input wire logic [5:0]  i_offset,
    input wire logic [6:0]  i_file_addr, o_file_waddr,
    input wire logic [7:0]  i_literal, i_file_rdata, i_mem_rdata,
    input wire logic [7:0]  o_file_wdata, o_mem_wdata, o_accum,
    input wire logic [4:0]  o_bank_select_reg,
    input wire logic [6:0]  o_pc_high_latch,
    input wire logic [15:0] o_mem_addr, o_file_pointer0, o_file_pointer1
);
    // Expected address is rebuilt here so a wrong carry into the top shows.
    wire logic [15:0] cur = i_ptr_sel ? o_file_pointer1 : o_file_pointer0;
    wire logic [15:0] stp = i_pointer_mode_field[0] ? 16'hFFFF : 16'h0001;
    wire logic [15:0] adj = i_relative ? 16'h0000 : stp;
    wire logic [15:0] exa = i_relative ? cur + {{10{i_offset[5]}}, i_offset}
                          : (i_pointer_mode_field[1] ? cur : cur + stp);
    wire logic        ind = i_valid && (i_op == 4'h2 || i_op == 4'h3);
    wire logic [6:0]  sh  = i_file_rdata[7:1];
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    sequence flags_kept; $stable({o_carry, o_zero}); endsequence
    a_shift_file: assert property (
        i_valid && i_op == 4'h1 && i_dest_sel |-> o_file_we &&
        o_file_wdata == {1'h0, sh}) else $error("shift write wrong");
    a_shift_flags: assert property (
        i_valid && i_op == 4'h1 |=>
        o_carry == $past(i_file_rdata[0]) && o_zero == ($past(sh) == 7'h00))
        else $error("shift flags wrong");
    a_ind_addr: assert property (
        ind |-> o_mem_addr == exa) else $error("indirect address wrong");
    a_ptr_step: assert property (ind |=>
        ($past(i_ptr_sel) ? o_file_pointer1 : o_file_pointer0) ==
        $past(cur) + $past(adj)) else $error("pointer update wrong");
    a_load_zero: assert property (
        ind && i_op == 4'h2 |=>
        o_accum == $past(i_mem_rdata) && o_zero == (o_accum == 8'h00))
        else $error("indirect load wrong");
    a_store_keeps: assert property (
        ind && i_op == 4'h3 |->
        o_mem_we && o_mem_wdata == o_accum ##1 flags_kept)
        else $error("indirect store wrong");
    a_lit_accum: assert property (i_valid && i_op == 4'h6 |=>
        o_accum == $past(i_literal) ##0 flags_kept) else $error("literal");
    a_bank_load: assert property (i_valid && i_op == 4'h4 |=>
        o_bank_select_reg == $past(i_literal[4:0]) ##0 flags_kept)
        else $error("bank load wrong");
    a_page_load: assert property (i_valid && i_op == 4'h5 |=>
        o_pc_high_latch == $past(i_literal[6:0]) ##0 flags_kept)
        else $error("page load wrong");
    a_accum_file: assert property (i_valid && i_op == 4'h7 |->
        o_file_we && o_file_waddr == i_file_addr && o_file_wdata == o_accum)
        else $error("accumulator to file wrong");
endmodule : msx_exec_monitor
bind msx_exec msx_exec_monitor msx_exec_monitor_i (.*);
`default_nettype wire

// *** tb/msx_exec_tb.sv ***
// Testbench for the shift, indirect and literal move executor.
`timescale 1ns/1ps
`default_nettype none
module msx_exec_tb;
    // Design ports and the bench's own model of the state.
    logic i_ref_clk = '0, i_rstn = '0, i_valid = '0, i_ptr_sel = '0, ec, ez;
    logic i_relative = '0, i_dest_sel = '0, o_file_we, o_mem_we, o_carry, o_zero;
    logic [3:0] i_op = '0, op;
    logic [1:0] i_pointer_mode_field = '0, md;
    logic [5:0] i_offset = '0;
    logic [6:0] i_file_addr = '0, o_file_waddr, o_pc_high_latch;
    logic [7:0] i_literal = '0, i_file_rdata = '0, i_mem_rdata = '0, ea, m;
    logic [7:0] o_file_wdata, o_mem_wdata, o_accum, sv [3];
    logic [4:0] o_bank_select_reg;
    logic [15:0] o_mem_addr, o_file_pointer0, o_file_pointer1, a, p [2];
    logic [32:0] cap;
    logic s;
    int n_mismatch = 0, cmp_count = 0;
    msx_exec msx_exec_i (.*);
    always #25 i_ref_clk = ~i_ref_clk;
    task automatic chk(input logic [47:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One instruction; the write strobes are sampled 1 ns after the instruction inputs are driven.
    task automatic exec(input logic [3:0] o, input logic [7:0] l, f, r,
        input logic [5:0] k, input logic [1:0] mo, input logic ps, rl, d);
        @(posedge i_ref_clk);
        {i_valid, i_op, i_literal, i_file_addr} <= {1'h1, o, l, l[6:0]};
        {i_file_rdata, i_mem_rdata, i_offset} <= {f, r, k};
        {i_pointer_mode_field, i_ptr_sel, i_relative, i_dest_sel} <= {mo, ps, rl, d};
        #1 cap = {o_file_we, o_mem_we, o_file_waddr, o_file_wdata, o_mem_addr};
        @(posedge i_ref_clk) i_valid <= 1'h0;
        #1;
    endtask : exec
    task automatic state();
        chk({o_accum, o_carry, o_zero, o_file_pointer0, o_file_pointer1},
            {ea, ec, ez, p[0], p[1]});
    endtask : state
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Main sequence; the model only moves on what the design should do.
    initial begin
        sv = '{8'h03, 8'h01, 8'h80};
        {ea, ec, ez, p[0], p[1]} = '0;
        repeat (10) @(posedge i_ref_clk);
        i_rstn <= 1'h1;
        #1 chk({o_bank_select_reg, o_pc_high_latch}, '0);
        state();
        for (int i = 0; i < 3; i++) begin
            exec(4'h1, 8'h00, sv[i], 8'h00, '0, '0, 1'h0, 1'h0, i == 0);
            {ec, ez} = {sv[i][0], sv[i][7:1] == 7'h00};
            if (i != 0) ea = {1'h0, sv[i][7:1]};
            chk(cap[32:16], {i == 0, 9'h000, sv[i][7:1]});
            state();
        end
        $display("shift test done");
        exec(4'h6, 8'h00, 8'h00, 8'h00, '0, '0, 1'h0, 1'h0, 1'h0);
        ea = 8'h00;
        state();
        exec(4'h4, 8'hFF, 8'h00, 8'h00, '0, '0, 1'h0, 1'h0, 1'h0);
        chk(o_bank_select_reg, 5'h1F);
        exec(4'h5, 8'hFF, 8'h00, 8'h00, '0, '0, 1'h0, 1'h0, 1'h0);
        chk(o_pc_high_latch, 7'h7F);
        exec(4'h6, 8'hA5, 8'h00, 8'h00, '0, '0, 1'h0, 1'h0, 1'h0);
        exec(4'h7, 8'h7F, 8'h00, 8'h00, '0, '0, 1'h0, 1'h0, 1'h0);
        ea = 8'hA5;
        chk(cap[32:16], {2'h2, 7'h7F, 8'hA5});
        exec(4'hF, 8'h00, 8'h00, 8'h00, '0, '0, 1'h0, 1'h0, 1'h0);
        state();
        $display("literal test done");
        for (int i = 0; i < 8; i++) begin
            {s, md, op, m} = {i[0], i[2:1] ^ 2'h1, 3'h1, i[1], i[2:0], 5'h00};
            a = md[0] ? p[s] - 16'h0001 : p[s] + 16'h0001;
            exec(op, 8'h00, 8'h00, m, '0, md, s, 1'h0, 1'h0);
            chk({cap[31], cap[15:0]}, {i[1], md[1] ? p[s] : a});
            p[s] = a;
            if (!i[1]) {ea, ez} = {m, m == 8'h00};
            state();
        end
        for (int i = 0; i < 2; i++) begin
            exec(4'h2, 8'h00, 8'h00, 8'h00, i ? 6'h1F : 6'h20, '0, 1'h1, 1'h1, 1'h0);
            {ea, ez} = {8'h00, 1'h1};
            chk(cap[15:0], 16'(p[1] + (i ? 16'h001F : 16'hFFE0)));
            state();
        end
        $display("indirect test done");
        conclude();
    end
    // Watchdog well beyond the few microseconds the tests need.
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule : msx_exec_tb
`default_nettype wire
